// ===== rtl/reset_watchdog_sleep_ctrl.sv
// Added by the designer: the Wishbone register port.
`include "rst_sleep_cfg.svh"

// Functional notes
// - any reset restores defaults, interrupts off
// - fetch restarts at 0x0000, internal clocking
// - power-on core clock is 24 MHz divided by eight
// - status bit 7 mirrors global interrupt enable
// - watchdog flag set by hardware, software clears
// - power-up flag set at power-on, blocks watchdog
// - power-on loads status with 00010000
// - sleep bit halts core until interrupt or reset
// - stop bit halts core until a reset
// - core held off about 20 ms after power-on
// - clearing power-up flag arms watchdog permanently
// - sleep timer on 32 kHz, interrupt per overflow
// - watchdog reset at third timer overflow
// - clear write zeroes watchdog; 0x38 zeroes timer
// - sleep forces internal clock, three-period recovery
// - sleep stops internal oscillator, crystal untouched
// - unmasked interrupt wakes regardless of enable
// - instruction after sleep write runs first
// - undervoltage monitor duty-cycled during sleep
// - sleep timer interrupt also fires while awake
// - sleep raises halt request; power-down after grant
// - wake aligned to 32 kHz edges in sequence
module reset_watchdog_sleep_ctrl #(
    parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES,
    parameter int unsigned TIMER_W     = 16
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  por_i,
    input  wire logic                  lp_clk_i,
    input  wire rst_sleep_pkg::wb_req_t wb_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  global_irq_enable_i,
    input  wire logic                  irq_pending_i,
    input  wire logic                  halt_grant_i,
    output logic                       core_reset_o,
    output logic [15:0]                reset_vector_o,
    output logic [3:0]                 core_clk_div_o,
    output logic                       core_clk_ext_o,
    output logic                       osc_internal_en_o,
    output logic                       osc_external_en_o,
    output logic                       halt_request_o,
    output logic                       power_down_line_o,
    output logic                       monitor_sample_o,
    output logic                       undervoltage_lowpower_o,
    output logic [1:0]                 sleep_duty_o,
    output logic                       sleep_timer_irq_o,
    output logic                       dog_reset_event_o
);
    import rst_sleep_pkg::*;

    localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);

    // =============================================================
    // pin synchronisers: three stages, change taken when 2nd and 3rd agree
    logic       por_s1, por_s2, por_s3, por_lvl_r;
    logic       lp_s1, lp_s2, lp_s3, lp_lvl_r;
    logic       lp_rise, lp_fall;

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            por_s1 <= por_i;
            por_s2 <= por_s1;
            por_s3 <= por_s2;
            lp_s1  <= lp_clk_i;
            lp_s2  <= lp_s1;
            lp_s3  <= lp_s2;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_lvl_r <= 1'b0;
            lp_lvl_r  <= 1'b0;
        end else if (ce_i) begin
            if (por_s2 == por_s3) begin
                por_lvl_r <= por_s3;
            end
            if (lp_s2 == lp_s3) begin
                lp_lvl_r <= lp_s3;
            end
        end
    end

    assign lp_rise = ce_i && (lp_s2 == lp_s3) && lp_s3 && !lp_lvl_r;
    assign lp_fall = ce_i && (lp_s2 == lp_s3) && !lp_s3 && lp_lvl_r;

    // =============================================================
    // reset sources
    logic hard_rst;
    logic all_rst;
    logic dog_rst_r;

    assign hard_rst = rst_i || por_lvl_r;
    assign all_rst  = hard_rst || dog_rst_r;

    // =============================================================
    // bus slave
    logic [7:0]  idx;
    logic        hit;
    logic        wr_go;
    logic        wr_scr;
    logic        wr_osc;
    logic        wr_clear;
    logic [7:0]  wdat;

    assign idx      = wb_i.adr[9:2];
    assign hit      = wb_i.cyc && wb_i.stb;
    assign wdat     = wb_i.dat[7:0];
    // write lands on the same edge the master samples ack
    assign wr_go    = ce_i && hit && wb_i.we && wb_ack_o && wb_i.sel[0];
    assign wr_scr   = wr_go && (idx == `IDX_STATUS);
    assign wr_osc   = wr_go && (idx == `IDX_OSC_CTRL);
    assign wr_clear = wr_go && (idx == `IDX_DOG_CLEAR);

    // =============================================================
    // status/control and oscillator control state
    logic         gie_r;
    logic         dog_flag_r;
    logic         pwr_flag_r;
    logic         sleep_r;
    logic         stop_r;
    logic [7:0]   osc_r;
    logic         sleep_nxt;
    logic         stop_nxt;
    sleep_state_t state_r;
    sleep_state_t state_nxt;
    logic [1:0]   rcv_r;
    logic         wake_done;

    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            gie_r <= 1'b0;
        end else if (ce_i) begin
            gie_r <= global_irq_enable_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            pwr_flag_r <= 1'((`SCR_POR_VALUE >> `SCR_PWR_BIT) & 8'h01);
            dog_flag_r <= 1'b0;
        end else if (dog_rst_r) begin
            pwr_flag_r <= 1'b0;
            dog_flag_r <= 1'b1;
        end else if (ce_i && wr_scr) begin
            // software may only clear the cause flags
            if (!wdat[`SCR_PWR_BIT]) begin
                pwr_flag_r <= 1'b0;
            end
            if (!wdat[`SCR_DOG_BIT]) begin
                dog_flag_r <= 1'b0;
            end
        end
    end

    assign wake_done = (state_r == ST_WREL) && lp_fall && (rcv_r == `RECOV_LP_EDGES);

    always_comb begin
        sleep_nxt = sleep_r;
        stop_nxt  = stop_r;
        if (wr_scr) begin
            if (wdat[`SCR_SLEEP_BIT]) begin
                sleep_nxt = 1'b1;
            end else if (state_r == ST_RUN) begin
                sleep_nxt = 1'b0;
            end
            if (wdat[`SCR_STOP_BIT]) begin
                stop_nxt = 1'b1;
            end
        end
        if (wake_done) begin
            sleep_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            sleep_r <= 1'b0;
            stop_r  <= 1'b0;
        end else if (ce_i) begin
            sleep_r <= sleep_nxt;
            stop_r  <= stop_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            osc_r <= `OSC_RESET_VALUE;
        end else if (ce_i) begin
            if (wr_osc) begin
                osc_r <= wdat & `OSC_WRITE_MASK;
            end
            if (state_r == ST_RUN && sleep_r) begin
                osc_r[`OSC_EXT_SEL_BIT] <= 1'b0;
            end
        end
    end

    // =============================================================
    // sleep timer and watchdog
    logic [TIMER_W-1:0] st_cnt_r;
    logic [TIMER_W-1:0] st_term;
    logic               st_ovf;
    logic [1:0]         dog_cnt_r;
    logic               dog_en_r;
    logic               dog_fire;

    assign st_term  = TIMER_W'((`PERIOD_BASE << osc_r[`OSC_PERIOD_LSB +: 3]) - 16'h0001);
    assign st_ovf   = lp_rise && (st_cnt_r == st_term);
    // a clear in the same cycle as the third overflow wins
    assign dog_fire = st_ovf && dog_en_r && !wr_clear && (dog_cnt_r == `DOG_FIRE_COUNT);

    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            st_cnt_r <= '0;
        end else if (ce_i) begin
            if (wr_clear && wdat == `CLEAR_BOTH_CODE) begin
                st_cnt_r <= '0;
            end else if (st_ovf) begin
                st_cnt_r <= '0;
            end else if (lp_rise) begin
                st_cnt_r <= st_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            dog_en_r <= 1'b0;
        end else if (ce_i && !pwr_flag_r) begin
            dog_en_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            dog_cnt_r <= 2'h0;
        end else if (ce_i) begin
            if (wr_clear) begin
                dog_cnt_r <= 2'h0;
            end else if (st_ovf && dog_en_r) begin
                dog_cnt_r <= dog_cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            dog_rst_r <= 1'b0;
        end else if (ce_i) begin
            dog_rst_r <= dog_fire && !pwr_flag_r;
        end
    end

    // =============================================================
    // sleep sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                if (sleep_r) begin
                    state_nxt = ST_REQ;
                end
            end
            ST_REQ: begin
                if (halt_grant_i) begin
                    state_nxt = ST_DOWN;
                end
            end
            ST_DOWN: begin
                // unmasked interrupt, global enable ignored
                if (irq_pending_i) begin
                    state_nxt = ST_WSYNC;
                end
            end
            ST_WSYNC: begin
                if (lp_fall) begin
                    state_nxt = ST_WPWR;
                end
            end
            ST_WPWR: begin
                if (lp_rise) begin
                    state_nxt = ST_WSAMP;
                end
            end
            ST_WSAMP: begin
                if (lp_rise) begin
                    state_nxt = ST_WREL;
                end
            end
            ST_WREL: begin
                if (wake_done) begin
                    state_nxt = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            state_r <= ST_RUN;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    // oscillator recovery counted in 32 kHz periods from power-up
    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            rcv_r <= 2'h0;
        end else if (ce_i) begin
            if (state_r == ST_WPWR && lp_rise) begin
                rcv_r <= 2'h1;
            end else if (state_r >= ST_WSAMP && lp_rise && rcv_r != `RECOV_LP_EDGES) begin
                rcv_r <= rcv_r + 2'h1;
            end
        end
    end

    // =============================================================
    // core-facing outputs
    logic [HOLD_W-1:0] hold_cnt_r;
    logic              pd_nxt;

    assign pd_nxt = (state_nxt == ST_DOWN) || (state_nxt == ST_WSYNC)
                 || (state_nxt == ST_WPWR);

    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            hold_cnt_r <= HOLD_W'(HOLD_CYCLES);
        end else if (ce_i && hold_cnt_r != '0) begin
            hold_cnt_r <= hold_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            core_reset_o      <= 1'b1;
            reset_vector_o    <= `RESET_VECTOR;
            core_clk_div_o    <= `CORE_DIV_POR;
            core_clk_ext_o    <= 1'b0;
            osc_internal_en_o <= 1'b1;
            osc_external_en_o <= 1'b0;
            halt_request_o    <= 1'b0;
            power_down_line_o <= 1'b0;
            monitor_sample_o  <= 1'b0;
            sleep_duty_o      <= 2'h0;
            sleep_timer_irq_o <= 1'b0;
            undervoltage_lowpower_o <= 1'b0;
        end else if (ce_i) begin
            core_reset_o      <= (hold_cnt_r > HOLD_W'(1));
            core_clk_ext_o    <= osc_r[`OSC_EXT_SEL_BIT];
            osc_internal_en_o <= !pd_nxt;
            osc_external_en_o <= osc_r[`OSC_XOSC_EN_BIT];
            halt_request_o    <= stop_nxt || sleep_nxt || (state_nxt != ST_RUN);
            power_down_line_o <= pd_nxt;
            monitor_sample_o  <= (state_r == ST_WSAMP) && lp_rise;
            sleep_duty_o      <= osc_r[`OSC_DUTY_LSB +: 2];
            undervoltage_lowpower_o <= pd_nxt;
            sleep_timer_irq_o <= st_ovf;
        end
    end

    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            dog_reset_event_o <= 1'b0;
        end else if (ce_i) begin
            dog_reset_event_o <= dog_rst_r;
        end
    end

    // =============================================================
    // bus answer: one wait state, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (all_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= hit && !wb_ack_o;
            if (hit && !wb_ack_o) begin
                unique case (idx)
                    `IDX_STATUS: begin
                        wb_dat_o <= {24'h000000, gie_r, 1'b0, dog_flag_r, pwr_flag_r,
                                     sleep_r, 2'b00, stop_r};
                    end
                    `IDX_OSC_CTRL: begin
                        wb_dat_o <= {24'h000000, osc_r};
                    end
                    default: begin
                        wb_dat_o <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // =============================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_status_por_val: assert property (disable iff (1'b0)
        rst_i |=> (pwr_flag_r && !dog_flag_r && !sleep_r && !stop_r && !gie_r))
        else $error("status not 00010000 after power-on");
    a_no_dog_pwr: assert property (pwr_flag_r |=> !dog_rst_r)
        else $error("watchdog reset while power-up flag set");
    a_dog_third_ovf: assert property ($rose(dog_rst_r) |->
        $past(dog_cnt_r) == `DOG_FIRE_COUNT && $past(st_ovf))
        else $error("watchdog reset not on third overflow");
    a_clear_zeroes: assert property (wr_clear && !all_rst |=> dog_cnt_r == 2'h0)
        else $error("clear write did not zero watchdog");
    a_sleep_halts: assert property (wr_scr && wdat[`SCR_SLEEP_BIT] |=> halt_request_o[*2])
        else $error("sleep write did not raise halt request");
    a_pd_after_grant: assert property (state_r == ST_REQ && halt_grant_i
        |=> power_down_line_o && halt_request_o)
        else $error("power-down missing after grant");
    a_clk_forced: assert property (power_down_line_o |-> !core_clk_ext_o)
        else $error("core clock not internal in sleep");
    a_stop_holds: assert property (stop_r && !all_rst |=> halt_request_o)
        else $error("stop released halt request");
    a_dog_sticky: assert property ($fell(pwr_flag_r) && !dog_rst_r
        |=> ##[0:2] dog_en_r)
        else $error("watchdog not armed after flag clear");

    c_sleep_wake: cover property (state_r == ST_WREL ##1 state_r == ST_RUN);
    c_dog_reset: cover property ($rose(dog_rst_r));
    c_clear_both: cover property (wr_clear && wdat == `CLEAR_BOTH_CODE);

endmodule

// ===== rtl/rst_sleep_cfg.svh
`ifndef RST_SLEEP_CFG_SVH
`define RST_SLEEP_CFG_SVH

// =============================================================
// register indices (byte address = 4 * index)
`define IDX_DOG_CLEAR    8'hE3
`define IDX_STATUS       8'hFF
`define IDX_OSC_CTRL     8'hE0

// =============================================================
// status/control field positions
`define SCR_GIE_BIT      7
`define SCR_DOG_BIT      5
`define SCR_PWR_BIT      4
`define SCR_SLEEP_BIT    3
`define SCR_STOP_BIT     0

// =============================================================
// oscillator control field positions
`define OSC_PERIOD_LSB   0
`define OSC_EXT_SEL_BIT  3
`define OSC_XOSC_EN_BIT  4
`define OSC_DUTY_LSB     5
`define OSC_WRITE_MASK   8'h7F

// =============================================================
// reset values and codes
`define SCR_POR_VALUE    8'h10
`define OSC_RESET_VALUE  8'h00
`define CLEAR_BOTH_CODE  8'h38
`define RESET_VECTOR     16'h0000
`define CORE_DIV_POR     4'h8
`define PERIOD_BASE      16'h0040

// =============================================================
// timing
`define CLK_MHZ          125
`define HOLD_TIME_US     20000
`define HOLD_CYCLES      (`HOLD_TIME_US * `CLK_MHZ)
`define DOG_FIRE_COUNT   2'h2
`define RECOV_LP_EDGES   2'h3

`endif

// ===== rtl/rst_sleep_pkg.sv
package rst_sleep_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_REQ,
        ST_DOWN,
        ST_WSYNC,
        ST_WPWR,
        ST_WSAMP,
        ST_WREL
    } sleep_state_t;

endpackage

// ===== sim/core_model.sv
module core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       halt_request_i,
    input  wire logic [1:0] lag_i,
    output logic            halt_grant_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] wait_r;

    // =========================================================
    // halt handshake
    // lag lets the bench play a core that reaches its boundary late
    always_ff @(posedge clk_i) begin
        if (rst_i || !halt_request_i) begin
            wait_r       <= 3'h0;
            halt_grant_o <= 1'b0;
        end else if (wait_r >= {1'b0, lag_i}) begin
            halt_grant_o <= 1'b1;
        end else begin
            wait_r <= wait_r + 3'h1;
        end
    end
endmodule

// ===== sim/tb_reset_watchdog_sleep_ctrl.sv
module tb_reset_watchdog_sleep_ctrl;
    import rst_sleep_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int HOLD = 20;
    localparam int LP   = 16;
    localparam int PER  = 64 * LP;
    localparam logic [9:0] A_SCR = 10'h3FC;
    localparam logic [9:0] A_CLR = 10'h38C;
    localparam logic [9:0] A_OSC = 10'h380;

    logic        clk_i;
    logic        rst_i;
    logic        por_i;
    logic        lp_clk_i;
    logic        global_irq_enable;
    logic        irq_pend;
    logic        grant;
    wb_req_t     wb;
    logic [31:0] dat;
    logic        ack;
    logic        core_rst;
    logic [15:0] vec;
    logic [3:0]  div;
    logic        clk_ext;
    logic        osc_int;
    logic        osc_ext;
    logic        halt_req;
    logic        pd;
    logic        mon;
    logic        uv;
    logic [1:0]  duty;
    logic [1:0]  lag;
    logic        tirq;
    logic        dog;
    logic [31:0] seed;
    logic [31:0] v;
    logic [31:0] q;
    int          errors;
    int          cmp_count;
    int          cyc;
    int          lp_div;
    int          irq_cnt;
    int          dog_cnt;
    int          mon_cnt;
    int          t_irq;
    int          t0;
    int          t_pd;
    int          k;
    int          s;
    int          d;

    reset_watchdog_sleep_ctrl #(.HOLD_CYCLES(HOLD)) dut (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .ce_i                    (1'b1),
        .por_i                   (por_i),
        .lp_clk_i                (lp_clk_i),
        .wb_i                    (wb),
        .wb_dat_o                (dat),
        .wb_ack_o                (ack),
        .global_irq_enable_i     (global_irq_enable),
        .irq_pending_i           (irq_pend),
        .halt_grant_i            (grant),
        .core_reset_o            (core_rst),
        .reset_vector_o          (vec),
        .core_clk_div_o          (div),
        .core_clk_ext_o          (clk_ext),
        .osc_internal_en_o       (osc_int),
        .osc_external_en_o       (osc_ext),
        .halt_request_o          (halt_req),
        .power_down_line_o       (pd),
        .monitor_sample_o        (mon),
        .undervoltage_lowpower_o (uv),
        .sleep_duty_o            (duty),
        .sleep_timer_irq_o       (tirq),
        .dog_reset_event_o       (dog)
    );

    core_model core (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .halt_request_i (halt_req),
        .lag_i          (lag),
        .halt_grant_o   (grant)
    );

    // =========================================================
    // clocks and monitors
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // low-power clock sped up to LP system cycles so timer runs stay short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        lp_div <= (lp_div == LP - 1) ? 0 : lp_div + 1;
        lp_clk_i <= (lp_div < LP / 2);
        if (tirq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            t_irq <= cyc;
        end
        if (dog === 1'b1) begin
            dog_cnt <= dog_cnt + 1;
        end
        if (mon === 1'b1) begin
            mon_cnt <= mon_cnt + 1;
        end
    end

    // =========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] dv);
        int n;
        n = 0;
        wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: {24'h0, dv}};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(ack), 32'h1);
        q = dat;
        wb <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask

    task automatic wait_irq(input int n);
        int st;
        int w;
        st = irq_cnt;
        w = 0;
        while (irq_cnt < st + n && w < 5000 * n) begin
            @(posedge clk_i);
            w++;
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        results();
    end

    // =========================================================
    // tests
    initial begin
        seed = 32'hAAF737BC;
        rst_i = 1'b1;
        por_i = 1'b0;
        lp_clk_i = 1'b0;
        global_irq_enable = 1'b0;
        irq_pend = 1'b0;
        lag = 2'h0;
        wb = '0;
        {errors, cmp_count, cyc, lp_div, irq_cnt, dog_cnt, mon_cnt, t_irq} = '0;
        repeat (5) @(posedge clk_i);
        chk(32'(vec), 32'h0);
        chk(32'(div), 32'h8);
        rst_i <= 1'b0;
        k = 0;
        while (core_rst === 1'b1 && k < HOLD + 50) begin
            @(posedge clk_i);
            k++;
        end
        chk_in(k, HOLD, HOLD + 3);
        rd(A_SCR, 8'h10);
        rd(A_OSC, 8'h00);
        bus(1'b1, 10'h004, 8'h5A);
        rd(10'h004, 8'h00);
        $display("test reset done");

        for (int i = 0; i < 4; i++) begin
            v = rnd();
            global_irq_enable <= v[8];
            bus(1'b1, A_SCR, 8'h30);
            rd(A_SCR, {v[8], 7'h10});
            v = rnd() & 32'hF7;
            bus(1'b1, A_OSC, v[7:0]);
            rd(A_OSC, v[7:0] & 8'h77);
            chk(32'({duty, osc_ext}), 32'(v[6:4]));
        end
        $display("test fields done");

        // watchdog stays disarmed here, so the timer runs cannot reset us
        for (int p = 1; p >= 0; p--) begin
            bus(1'b1, A_OSC, 8'(p));
            bus(1'b1, A_CLR, 8'h38);
            wait_irq(1);
            t0 = cyc;
            wait_irq(1);
            chk_in(cyc - t0, PER << p, PER << p);
            repeat (300) @(posedge clk_i);
            bus(1'b1, A_CLR, 8'h38);
            t0 = cyc;
            wait_irq(1);
            chk_in(cyc - t0, (PER << p) - LP - 8, (PER << p) + 8);
        end
        chk(32'(dog_cnt), 32'h0);
        $display("test timer done");

        v = rnd();
        bus(1'b1, A_OSC, {1'b0, v[1:0], 5'h18});
        @(posedge clk_i);
        chk(32'(clk_ext), 32'h1);
        lag <= v[3:2];
        global_irq_enable <= 1'b0;
        bus(1'b1, A_SCR, 8'h18);
        @(posedge clk_i);
        chk(32'(halt_req), 32'h1);
        k = 0;
        while (pd !== 1'b1 && k < 20) begin
            @(posedge clk_i);
            k++;
        end
        chk(32'({osc_int, osc_ext, clk_ext, uv}), 32'h5);
        chk(32'(duty), 32'(v[1:0]));
        repeat (8 * LP) @(posedge clk_i);
        chk(32'(pd), 32'h1);
        irq_pend <= 1'b1;
        s = mon_cnt;
        t_pd = 0;
        k = 0;
        while (halt_req !== 1'b0 && k < 400) begin
            @(posedge clk_i);
            k++;
            if (pd !== 1'b1 && t_pd == 0) begin
                t_pd = k;
            end
        end
        irq_pend <= 1'b0;
        chk_in(t_pd, 1, 399);
        chk_in(k - t_pd, 2 * LP, 6 * LP);
        chk(32'(mon_cnt - s), 32'h1);
        rd(A_SCR, 8'h10);
        rd(A_OSC, {1'b0, v[1:0], 5'h10});
        bus(1'b1, A_OSC, {1'b0, v[1:0], 5'h18});
        @(posedge clk_i);
        chk(32'({clk_ext, osc_int}), 32'h3);
        bus(1'b1, A_OSC, {1'b0, v[1:0], 5'h10});
        bus(1'b1, A_OSC, {1'b0, v[1:0], 5'h00});
        @(posedge clk_i);
        chk(32'(osc_ext), 32'h0);
        $display("test sleep done");

        bus(1'b1, A_SCR, 8'h00);
        rd(A_SCR, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wait_irq(1);
            v = rnd();
            bus(1'b1, A_CLR, (v[7:0] == 8'h38) ? 8'h39 : v[7:0]);
        end
        chk(32'(dog_cnt), 32'h0);
        bus(1'b1, A_CLR, 8'h38);
        s = irq_cnt;
        d = dog_cnt;
        k = 0;
        while (dog_cnt == d && k < 4 * PER) begin
            @(posedge clk_i);
            k++;
        end
        chk(32'(irq_cnt - s), 32'h3);
        chk_in(cyc - t_irq, 0, 4);
        rd(A_SCR, 8'h20);
        rd(A_OSC, 8'h00);
        chk(32'(vec), 32'h0);
        bus(1'b1, A_SCR, 8'h00);
        rd(A_SCR, 8'h00);
        $display("test watchdog done");

        bus(1'b1, A_SCR, 8'h01);
        rd(A_SCR, 8'h01);
        por_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        por_i <= 1'b0;
        k = 0;
        while (core_rst === 1'b1 && k < HOLD + 50) begin
            @(posedge clk_i);
            k++;
        end
        chk_in(k, HOLD, HOLD + 8);
        rd(A_SCR, 8'h10);
        d = dog_cnt;
        wait_irq(4);
        chk(32'(dog_cnt - d), 32'h0);
        $display("test power-on done");
        results();
    end
endmodule
